// ===== core/lvds_routing_defs.svh
/*
  Register indices, field positions, reset values and masks of the LVDS
  output routing and configuration block.
  Assumes inclusion by bare name; byte address is four times the index.
*/
`ifndef LVDS_ROUTING_DEFS_SVH
`define LVDS_ROUTING_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define IDX_STREAM_CFG   8'h10
`define IDX_LINK_CFG     8'h18
`define IDX_ROUTE_TERM   8'h1a
`define IDX_CM_ADJUST    8'h1b
`define IDX_LINE_LOW     8'h20
`define IDX_LINE_HIGH    8'h21
`define IDX_VSIZE_LOW    8'h24
`define IDX_TEST_PAT     8'h3c
`define IDX_STATUS       8'h40

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STREAM_LSB       5
`define LINK_SINGLE_BIT  4
`define SWAP_BIT         6
`define FLIP_A_BIT       5
`define FLIP_B_BIT       4
`define TERM_A_BIT       1
`define TERM_B_BIT       0
`define CM_A_LSB         4
`define CM_B_LSB         0
`define TEST_PAT_BIT     4

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define RST_STREAM_CFG   8'h00
`define RST_LINK_CFG     8'h70
`define RST_ROUTE_TERM   8'h03
`define RST_CM_ADJUST    8'h00
`define RST_LINE         8'h00
`define RST_VSIZE        8'h00
`define RST_TEST_PAT     8'h00
`define MASK_STREAM_CFG  8'h60
`define MASK_ROUTE_TERM  8'h73
`define MASK_CM_ADJUST   8'h33
`define MASK_LINE_HIGH   8'h0f
`define MASK_TEST_PAT    8'h10

// ----------------------------------------------------------------------
// Lane layout
// ----------------------------------------------------------------------
`define LANE_W           7
`define LANE_COUNT       5
`define CLK_LANE_WORD    7'h63

`endif

// ===== core/lvds_routing_pkg.sv
/*
  Types shared by the LVDS output routing block.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package lvds_routing_pkg;

  typedef enum logic [1:0] {
    route_single     = 2'b00,
    route_dual       = 2'b01,
    route_two_stream = 2'b10
  } route_mode_t;

  typedef logic [6:0] lane_word_t;

endpackage

`default_nettype wire

// ===== core/lane_order_mux.sv
/*
  Lane reordering for one LVDS channel, slots {clk,y3,y2,y1,y0}.
  Assumes the caller registers the result; the mux is combinational.
*/
`default_nettype none
`include "lvds_routing_defs.svh"

module lane_order_mux
  import lvds_routing_pkg::*;
(
  input  wire logic        flip,
  input  wire logic [34:0] lanes_in,
  output logic      [34:0] lanes_out
);

  // Flipped order: slot 0 with 3, slot 1 with the clock slot 4.
  function automatic int flip_slot(input int slot);
    case (slot)
      0:       flip_slot = 3;
      1:       flip_slot = 4;
      3:       flip_slot = 0;
      4:       flip_slot = 1;
      default: flip_slot = slot;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < `LANE_COUNT; g = g + 1) begin : g_slot
      assign lanes_out[g*`LANE_W +: `LANE_W] = flip ?
        lanes_in[flip_slot(g)*`LANE_W +: `LANE_W] :
        lanes_in[g*`LANE_W +: `LANE_W];
    end
  endgenerate

endmodule // lane_order_mux

`default_nettype wire

// ===== core/lvds_output_routing_config.sv
/*
  Output routing and configuration of a DSI to LVDS bridge: even/odd
  steering, stream swap, lane-order flip, termination and common-mode
  selects, active line length and test-pattern vertical size.
  Assumes an Avalon-MM master with waitrequest on the same clock and
  pixel words, already split into four 7-bit lanes, on the same clock.
*/
// Our own choice: the Avalon-MM register port.
`default_nettype none
`include "lvds_routing_defs.svh"

module lvds_output_routing_config
  import lvds_routing_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        pix_valid,
  input  wire logic        pix_sol,
  input  wire logic [27:0] pix_a_data,
  input  wire logic [27:0] pix_b_data,
  output logic             lvds_a_enable,
  output logic             lvds_a_valid,
  output logic             lvds_a_eol,
  output logic      [34:0] lvds_a_lanes,
  output logic             lvds_b_enable,
  output logic             lvds_b_valid,
  output logic             lvds_b_eol,
  output logic      [34:0] lvds_b_lanes,
  output logic             termination_select_a,
  output logic             termination_select_b,
  output logic      [1:0]  common_mode_trim_a,
  output logic      [1:0]  common_mode_trim_b,
  output logic      [11:0] line_pixels,
  output logic      [7:0]  tp_frame_lines_low
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // --------------------------------------------------------------------
  // Avalon-MM slave
  // --------------------------------------------------------------------
  logic [7:0] stream_cfg;
  logic [7:0] link_cfg;
  logic [7:0] route_term;
  logic [7:0] cm_adjust;
  logic [7:0] line_pixels_low;
  logic [7:0] line_pixels_high;
  logic [7:0] frame_lines_low;
  logic [7:0] test_pat;
  logic [7:0] status;
  logic [7:0] reg_index;
  logic       wr_take;
  logic [7:0] wdata;

  assign reg_index = address[9:2];
  assign wdata     = writedata[7:0];
  assign wr_take   = write && !waitrequest && byteenable[0];

  // Each request is answered one cycle after it is first seen.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if (waitrequest) begin
      waitrequest <= !(read || write);
    end else begin
      waitrequest <= 1'b1;
    end
  end

  function automatic logic [7:0] read_mux(input logic [7:0] idx);
    if (idx == `IDX_STREAM_CFG) begin
      read_mux = stream_cfg;
    end else if (idx == `IDX_LINK_CFG) begin
      read_mux = link_cfg;
    end else if (idx == `IDX_ROUTE_TERM) begin
      read_mux = route_term;
    end else if (idx == `IDX_CM_ADJUST) begin
      read_mux = cm_adjust;
    end else if (idx == `IDX_LINE_LOW) begin
      read_mux = line_pixels_low;
    end else if (idx == `IDX_LINE_HIGH) begin
      read_mux = line_pixels_high;
    end else if (idx == `IDX_VSIZE_LOW) begin
      read_mux = frame_lines_low;
    end else if (idx == `IDX_TEST_PAT) begin
      read_mux = test_pat;
    end else if (idx == `IDX_STATUS) begin
      read_mux = status;
    end else begin
      read_mux = 8'h00;
    end
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= {24'h00_0000, read_mux(reg_index)};
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stream_cfg       <= `RST_STREAM_CFG;
      link_cfg         <= `RST_LINK_CFG;
      route_term       <= `RST_ROUTE_TERM;
      cm_adjust        <= `RST_CM_ADJUST;
      line_pixels_low  <= `RST_LINE;
      line_pixels_high <= `RST_LINE;
      frame_lines_low  <= `RST_VSIZE;
      test_pat         <= `RST_TEST_PAT;
    end else if (wr_take) begin
      if (reg_index == `IDX_STREAM_CFG) begin
        stream_cfg <= wdata & `MASK_STREAM_CFG;
      end else if (reg_index == `IDX_LINK_CFG) begin
        link_cfg <= wdata;
      end else if (reg_index == `IDX_ROUTE_TERM) begin
        route_term <= wdata & `MASK_ROUTE_TERM;
      end else if (reg_index == `IDX_CM_ADJUST) begin
        cm_adjust <= wdata & `MASK_CM_ADJUST;
      end else if (reg_index == `IDX_LINE_LOW) begin
        line_pixels_low <= wdata;
      end else if (reg_index == `IDX_LINE_HIGH) begin
        line_pixels_high <= wdata & `MASK_LINE_HIGH;
      end else if (reg_index == `IDX_VSIZE_LOW) begin
        frame_lines_low <= wdata;
      end else if (reg_index == `IDX_TEST_PAT) begin
        test_pat <= wdata & `MASK_TEST_PAT;
      end
    end
  end

  // --------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------
  route_mode_t mode;
  logic        swap;
  logic        tp_on;
  logic [11:0] line_len;

  assign swap     = route_term[`SWAP_BIT];
  assign tp_on    = test_pat[`TEST_PAT_BIT];
  assign line_len = {line_pixels_high[3:0], line_pixels_low};

  always_comb begin
    if (link_cfg[`LINK_SINGLE_BIT]) begin
      mode = route_single;
    end else if (stream_cfg[6:5] == 2'b10) begin
      mode = route_two_stream;
    end else begin
      mode = route_dual;
    end
  end

  // --------------------------------------------------------------------
  // Pixel position within the line
  // --------------------------------------------------------------------
  logic [11:0] pix_count;
  logic        pix_even;
  logic        line_last;
  logic [11:0] count_base;

  // The first pixel of a line is pixel one, an odd pixel.
  assign count_base = pix_sol ? 12'h000 : pix_count;
  assign pix_even   = count_base[0];
  assign line_last  = (line_len != 12'h000) &&
                      (count_base == line_len - 12'h001);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pix_count <= 12'h000;
    end else if (pix_valid) begin
      pix_count <= line_last ? 12'h000 : count_base + 12'h001;
    end else if (pix_sol) begin
      pix_count <= 12'h000;
    end
  end

  // --------------------------------------------------------------------
  // Channel steering
  // --------------------------------------------------------------------
  logic        to_a;
  logic        to_b;
  logic [27:0] a_src;
  logic [27:0] b_src;
  logic [34:0] a_flipped;
  logic [34:0] b_flipped;

  always_comb begin
    to_a  = 1'b0;
    to_b  = 1'b0;
    a_src = pix_a_data;
    b_src = pix_a_data;
    case (mode)
      route_single: begin
        to_a = pix_valid;
      end
      route_two_stream: begin
        to_a  = pix_valid;
        to_b  = pix_valid;
        a_src = swap ? pix_b_data : pix_a_data;
        b_src = swap ? pix_a_data : pix_b_data;
      end
      default: begin
        to_a = pix_valid && (pix_even == swap);
        to_b = pix_valid && (pix_even != swap);
      end
    endcase
  end

  lane_order_mux u_flip_a (
    .flip      (route_term[`FLIP_A_BIT]),
    .lanes_in  ({`CLK_LANE_WORD, a_src}),
    .lanes_out (a_flipped)
  );

  lane_order_mux u_flip_b (
    .flip      (route_term[`FLIP_B_BIT]),
    .lanes_in  ({`CLK_LANE_WORD, b_src}),
    .lanes_out (b_flipped)
  );

  // --------------------------------------------------------------------
  // Registered LVDS outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lvds_a_enable <= 1'b1;
      lvds_a_valid  <= 1'b0;
      lvds_a_eol    <= 1'b0;
      lvds_a_lanes  <= 35'h0_0000_0000;
    end else begin
      lvds_a_enable <= 1'b1;
      lvds_a_valid  <= to_a;
      lvds_a_eol    <= pix_valid && line_last;
      lvds_a_lanes  <= to_a ? a_flipped : 35'h0_0000_0000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lvds_b_enable <= 1'b0;
      lvds_b_valid  <= 1'b0;
      lvds_b_eol    <= 1'b0;
      lvds_b_lanes  <= 35'h0_0000_0000;
    end else begin
      lvds_b_enable <= (mode != route_single);
      lvds_b_valid  <= to_b;
      lvds_b_eol    <= pix_valid && line_last &&
                       (mode != route_single);
      lvds_b_lanes  <= to_b ? b_flipped : 35'h0_0000_0000;
    end
  end

  // --------------------------------------------------------------------
  // Analog selects and video fields
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      termination_select_a <= 1'b1;
      termination_select_b <= 1'b1;
      common_mode_trim_a   <= 2'b00;
      common_mode_trim_b   <= 2'b00;
    end else begin
      termination_select_a <= route_term[`TERM_A_BIT];
      termination_select_b <= route_term[`TERM_B_BIT];
      common_mode_trim_a   <= cm_adjust[`CM_A_LSB +: 2];
      common_mode_trim_b   <= cm_adjust[`CM_B_LSB +: 2];
    end
  end

  // The vertical size reaches the pattern generator only while it runs.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_pixels        <= 12'h000;
      tp_frame_lines_low <= 8'h00;
    end else begin
      line_pixels        <= line_len;
      tp_frame_lines_low <= tp_on ? frame_lines_low : 8'h00;
    end
  end

  assign status = {4'h0, tp_on, pix_count[0], mode};

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_odd_to_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (pix_valid && mode == route_dual && !swap && !pix_even)
      |=> (lvds_a_valid && !lvds_b_valid))
    else $error("odd pixel not on channel A");

  a_swap_odd_to_b: assert property (
    @(posedge clock) disable iff (!rst_n)
    (pix_valid && mode == route_dual && swap && !pix_even)
      |=> (lvds_b_valid && !lvds_a_valid))
    else $error("swapped odd pixel not on channel B");

  a_stream_swap: assert property (
    @(posedge clock) disable iff (!rst_n)
    (pix_valid && mode == route_two_stream && swap &&
     !route_term[`FLIP_A_BIT] && !route_term[`FLIP_B_BIT])
      |=> (lvds_a_lanes[27:0] == $past(pix_b_data) &&
           lvds_b_lanes[27:0] == $past(pix_a_data)))
    else $error("two-stream swap not applied");

  a_flip_a_lanes: assert property (
    @(posedge clock) disable iff (!rst_n)
    (to_a && route_term[`FLIP_A_BIT])
      |=> (lvds_a_lanes[6:0] == $past(a_src[27:21]) &&
           lvds_a_lanes[13:7] == `CLK_LANE_WORD &&
           lvds_a_lanes[27:21] == $past(a_src[6:0]) &&
           lvds_a_lanes[20:14] == $past(a_src[20:14]) &&
           lvds_a_lanes[34:28] == $past(a_src[13:7])))
    else $error("channel A lanes not flipped");

  a_flip_b_lanes: assert property (
    @(posedge clock) disable iff (!rst_n)
    (to_b && !route_term[`FLIP_B_BIT])
      |=> (lvds_b_lanes == {`CLK_LANE_WORD, $past(b_src)}))
    else $error("channel B lanes changed without flip");

  a_term_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    (wr_take && reg_index == `IDX_ROUTE_TERM)
      |=> ##1 (termination_select_a == $past(wdata[1], 2) &&
               termination_select_b == $past(wdata[0], 2)))
    else $error("termination select not following write");

  a_cm_trim: assert property (
    @(posedge clock) disable iff (!rst_n)
    (wr_take && reg_index == `IDX_CM_ADJUST)
      |=> ##1 (common_mode_trim_a == $past(wdata[5:4], 2) &&
               common_mode_trim_b == $past(wdata[1:0], 2)))
    else $error("common-mode trim not following write");

  a_line_end: assert property (
    @(posedge clock) disable iff (!rst_n)
    (pix_valid && line_last) |=> (lvds_a_eol && pix_count == 12'h000))
    else $error("line end not marked at programmed length");

  a_eol_b_dual: assert property (
    @(posedge clock) disable iff (!rst_n)
    lvds_b_eol |-> ($past(mode) != route_single && lvds_a_eol))
    else $error("channel B line end outside dual-link");

  a_frame_gate: assert property (
    @(posedge clock) disable iff (!rst_n)
    (!tp_on) |=> (tp_frame_lines_low == 8'h00))
    else $error("vertical size leaked outside test pattern");

  a_single_b_off: assert property (
    @(posedge clock) disable iff (!rst_n)
    (link_cfg[`LINK_SINGLE_BIT]) |=> (!lvds_b_enable && !lvds_b_valid))
    else $error("channel B active in single-link");

  a_bus_answer: assert property (
    @(posedge clock) disable iff (!rst_n)
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle after request");

endmodule // lvds_output_routing_config

`default_nettype wire

// ===== dv/lvds_panel_model.sv
/*
  Behavioural LVDS panel at the far side of the routing block.
  Assumes lane words and strobes change only after rising clock edges.
*/
`default_nettype none

module lvds_panel_model (
  input wire logic        clock,
  input wire logic        a_enable,
  input wire logic        a_valid,
  input wire logic        a_eol,
  input wire logic [34:0] a_lanes,
  input wire logic        b_enable,
  input wire logic        b_valid,
  input wire logic [34:0] b_lanes,
  input wire logic        b_eol
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [34:0] last_a = 35'h0;
  logic [34:0] last_b = 35'h0;
  int          count_a = 0;
  int          count_b = 0;
  int          eol_a = 0;
  int          eol_b = 0;

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // A disabled channel is dark at the panel, so nothing is taken there.
  always @(posedge clock) begin
    if (a_enable === 1'h1 && a_valid === 1'h1) begin
      last_a  <= a_lanes;
      count_a <= count_a + 1;
      if (a_eol === 1'h1) begin
        eol_a <= eol_a + 1;
      end
    end
    if (b_enable === 1'h1 && b_valid === 1'h1) begin
      last_b  <= b_lanes;
      count_b <= count_b + 1;
    end
    // Line end on B is counted whether or not B carries that pixel.
    if (b_enable === 1'h1 && b_eol === 1'h1) begin
      eol_b <= eol_b + 1;
    end
  end
endmodule // lvds_panel_model

`default_nettype wire

// ===== dv/test_lvds_output_routing_config.sv
/*
  Self-checking bench of the LVDS output routing block.
  Assumes the design files and the panel model are compiled first.
*/
`default_nettype none
`include "lvds_routing_defs.svh"

module test_lvds_output_routing_config;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock, nrst, read, write, waitrequest;
  logic [9:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd;
  logic        pix_valid, pix_sol;
  logic [27:0] pix_a_data, pix_b_data;
  logic        lvds_a_enable, lvds_a_valid, lvds_a_eol;
  logic        lvds_b_enable, lvds_b_valid, lvds_b_eol;
  logic [34:0] lvds_a_lanes, lvds_b_lanes, seen_a, seen_b;
  logic        termination_select_a, termination_select_b;
  logic [1:0]  common_mode_trim_a, common_mode_trim_b;
  logic [11:0] line_pixels;
  logic [7:0]  tp_frame_lines_low;
  int          failures, checked;

  lvds_output_routing_config i_lvds_output_routing_config (
    .clock, .nrst, .address, .read, .write, .byteenable, .writedata,
    .readdata, .waitrequest, .pix_valid, .pix_sol, .pix_a_data,
    .pix_b_data, .lvds_a_enable, .lvds_a_valid, .lvds_a_eol,
    .lvds_a_lanes, .lvds_b_enable, .lvds_b_valid, .lvds_b_eol,
    .lvds_b_lanes, .termination_select_a, .termination_select_b,
    .common_mode_trim_a, .common_mode_trim_b, .line_pixels,
    .tp_frame_lines_low);

  lvds_panel_model i_lvds_panel_model (
    .clock(clock), .a_enable(lvds_a_enable), .a_valid(lvds_a_valid),
    .a_eol(lvds_a_eol), .a_lanes(lvds_a_lanes),
    .b_enable(lvds_b_enable), .b_valid(lvds_b_valid),
    .b_lanes(lvds_b_lanes), .b_eol(lvds_b_eol));

  assign seen_a = i_lvds_panel_model.last_a;
  assign seen_b = i_lvds_panel_model.last_b;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_reg(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_lanes(string what, logic [34:0] exp,
                             logic [34:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Lane word {clk,y3,y2,y1,y0}; a flip swaps y0/y3 and y1/clk.
  function automatic logic [34:0] lanes_of(logic [27:0] d, logic flip);
    if (flip) begin
      return {d[13:7], d[6:0], d[20:14], `CLK_LANE_WORD, d[27:21]};
    end
    return {`CLK_LANE_WORD, d};
  endfunction

  task automatic bus(logic wr, logic [7:0] idx, logic [7:0] wd,
                     logic [3:0] be);
    int n;
    @(posedge clock);
    address    <= {idx, 2'h0};
    read       <= !wr;
    write      <= wr;
    writedata  <= {24'h0, wd};
    byteenable <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (waitrequest === 1'h0) break;
    end
    if (n == 20) begin
      failures++;
      report_and_stop();
    end
    rd = readdata;
    read  <= 1'h0;
    write <= 1'h0;
  endtask

  task automatic wr(logic [7:0] idx, logic [7:0] wd);
    bus(1'h1, idx, wd, 4'h1);
  endtask

  task automatic rdchk(logic [7:0] idx, logic [7:0] exp, string what);
    bus(1'h0, idx, 8'h00, 4'h1);
    check_reg(what, {24'h0, exp}, rd);
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic pix(logic sol, logic [27:0] a, logic [27:0] b);
    @(posedge clock);
    pix_valid  <= 1'h1;
    pix_sol    <= sol;
    pix_a_data <= a;
    pix_b_data <= b;
    @(posedge clock);
    pix_valid <= 1'h0;
    pix_sol   <= 1'h0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check_reg("term_a", 1'h1, termination_select_a);
    check_reg("term_b", 1'h1, termination_select_b);
    check_reg("trims", 4'h0,
              {common_mode_trim_a, common_mode_trim_b});
    check_reg("line_pixels", 12'h0, line_pixels);
    check_reg("tp_lines", 8'h0, tp_frame_lines_low);
    check_reg("enables", 2'h2, {lvds_a_enable, lvds_b_enable});
    rdchk(`IDX_ROUTE_TERM, 8'h03, "route_term");
    rdchk(`IDX_CM_ADJUST, 8'h00, "cm_adjust");
    rdchk(`IDX_LINE_LOW, 8'h00, "line_low");
    rdchk(`IDX_LINE_HIGH, 8'h00, "line_high");
    rdchk(`IDX_VSIZE_LOW, 8'h00, "vsize_low");
    rdchk(8'h05, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_steer();
    wr(`IDX_LINK_CFG, 8'h60);
    settle();
    check_reg("b_enable", 1'h1, lvds_b_enable);
    for (int s = 0; s < 2; s++) begin
      wr(`IDX_ROUTE_TERM, {1'h0, s[0], 6'h03});
      pix(1'h1, 28'h1234567, 28'h0);
      pix(1'h0, 28'h89abcde, 28'h0);
      settle();
      if (s == 0) begin
        check_lanes("odd a", lanes_of(28'h1234567, 1'h0), seen_a);
        check_lanes("even b", lanes_of(28'h89abcde, 1'h0), seen_b);
      end else begin
        check_lanes("odd b", lanes_of(28'h1234567, 1'h0), seen_b);
        check_lanes("even a", lanes_of(28'h89abcde, 1'h0), seen_a);
      end
    end
    wr(`IDX_ROUTE_TERM, 8'h33);
    pix(1'h1, 28'h0f1e2d3, 28'h0);
    pix(1'h0, 28'h4c5b6a7, 28'h0);
    settle();
    check_lanes("flip a", lanes_of(28'h0f1e2d3, 1'h1), seen_a);
    check_lanes("flip b", lanes_of(28'h4c5b6a7, 1'h1), seen_b);
    $display("test steering done");
  endtask

  task automatic t_two_stream();
    wr(`IDX_STREAM_CFG, 8'h40);
    wr(`IDX_ROUTE_TERM, 8'h43);
    pix(1'h1, 28'h2468ace, 28'h13579bd);
    settle();
    check_lanes("stream a", lanes_of(28'h2468ace, 1'h0), seen_b);
    check_lanes("stream b", lanes_of(28'h13579bd, 1'h0), seen_a);
    wr(`IDX_ROUTE_TERM, 8'h03);
    pix(1'h1, 28'h1122334, 28'h5566778);
    settle();
    check_lanes("stream a", lanes_of(28'h1122334, 1'h0), seen_a);
    check_lanes("stream b", lanes_of(28'h5566778, 1'h0), seen_b);
    wr(`IDX_STREAM_CFG, 8'h00);
    $display("test two stream done");
  endtask

  task automatic t_line();
    int e;
    int ca;
    int cb;
    wr(`IDX_LINE_LOW, 8'h03);
    wr(`IDX_LINE_HIGH, 8'hf2);
    settle();
    check_reg("line_pixels", 12'h203, line_pixels);
    rdchk(`IDX_LINE_HIGH, 8'h02, "line_high");
    wr(`IDX_LINE_HIGH, 8'h00);
    wr(`IDX_LINK_CFG, 8'h70);
    settle();
    check_reg("b_enable", 1'h0, lvds_b_enable);
    e  = i_lvds_panel_model.eol_a;
    ca = i_lvds_panel_model.count_a;
    cb = i_lvds_panel_model.count_b;
    pix(1'h1, 28'h0000001, 28'h0);
    pix(1'h0, 28'h0000002, 28'h0);
    settle();
    check_reg("early eol", 32'h0, i_lvds_panel_model.eol_a - e);
    pix(1'h0, 28'h0000003, 28'h0);
    settle();
    check_reg("eol", 32'h1, i_lvds_panel_model.eol_a - e);
    check_reg("a count", 32'h3, i_lvds_panel_model.count_a - ca);
    check_reg("b count", 32'h0, i_lvds_panel_model.count_b - cb);
    wr(`IDX_LINK_CFG, 8'h60);
    e = i_lvds_panel_model.eol_b;
    pix(1'h1, 28'h0000004, 28'h0);
    pix(1'h0, 28'h0000005, 28'h0);
    pix(1'h0, 28'h0000006, 28'h0);
    settle();
    check_reg("b eol", 32'h1, i_lvds_panel_model.eol_b - e);
    $display("test line length done");
  endtask

  task automatic t_analog();
    for (int c = 0; c < 4; c++) begin
      wr(`IDX_CM_ADJUST, {2'h0, c[1:0], 2'h0, ~c[1:0]});
      settle();
      check_reg("trim_a", c[1:0], common_mode_trim_a);
      check_reg("trim_b", 2'(~c[1:0]), common_mode_trim_b);
    end
    wr(`IDX_ROUTE_TERM, 8'h01);
    settle();
    check_reg("term", 2'h1,
              {termination_select_a, termination_select_b});
    $display("test analog selects done");
  endtask

  task automatic t_vsize();
    wr(`IDX_VSIZE_LOW, 8'h5a);
    bus(1'h1, `IDX_VSIZE_LOW, 8'hff, 4'h0);
    rdchk(`IDX_VSIZE_LOW, 8'h5a, "vsize_low");
    settle();
    check_reg("tp off", 8'h00, tp_frame_lines_low);
    wr(`IDX_TEST_PAT, 8'h10);
    settle();
    check_reg("tp on", 8'h5a, tp_frame_lines_low);
    $display("test vertical size done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    failures   = 0;
    checked    = 0;
    nrst       = 1'h0;
    address    = 10'h0;
    read       = 1'h0;
    write      = 1'h0;
    byteenable = 4'h0;
    writedata  = 32'h0;
    pix_valid  = 1'h0;
    pix_sol    = 1'h0;
    pix_a_data = 28'h0;
    pix_b_data = 28'h0;
    repeat (5) @(posedge clock);
    nrst <= 1'h1;
    repeat (3) @(posedge clock);
    #1;
    t_reset();
    t_steer();
    t_two_stream();
    t_line();
    t_analog();
    t_vsize();
    report_and_stop();
  end
endmodule // test_lvds_output_routing_config

`default_nettype wire
